// file: card_dev_model.sv
// behavioural card interface device: registers, flags, loopback and card clock
`timescale 1ns/1ns
`default_nettype none
module card_dev_model #(
	parameter int FRAME_CYC = 96,
	parameter int BURST_CYC = 92
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [3:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	output logic ack,
	output logic card_clk,
	input wire logic inj_go,
	input wire logic inj_bad,
	input wire logic [7:0] inj_byte,
	input wire logic inj_nak
);
	import card_host_pkg::*;
	logic [7:0] regs [0:7];
	logic [11:0] tx_cnt_r;
	logic [1:0] div_r;
	logic nak_r;
	wire take = (wr || rd) && !ack;
	wire [7:0] ctl = regs[OFS_CTRL];
	wire burst = regs[OFS_MODE][MODE_BURST];
	// frame plus guard: FRAME_CYC (96) cycles normally, BURST_CYC (92) and no resend in burst mode
	wire [11:0] frame_len = burst ? 12'(BURST_CYC) : 12'(FRAME_CYC);
	always @(posedge clk) begin
		if (rst) begin
			for (int i = 0; i < 8; i++)
				regs[i] <= 8'h00;
			regs[OFS_STAT] <= 8'h84;
			ack <= 1'b0;
			rdata <= 8'h00;
			tx_cnt_r <= 12'h000;
			div_r <= 2'h0;
			card_clk <= 1'b0;
			nak_r <= 1'b0;
		end else begin
			ack <= take;
			// read data turns to garbage once the ack has passed
			if (take && rd)
				rdata <= regs[addr[2:0]];
			else if (ack)
				rdata <= ~rdata;
			if (take && wr && addr == OFS_STAT)
				regs[OFS_STAT] <= regs[OFS_STAT] & wdata;
			else if (take && wr && addr == OFS_TXD) begin
				regs[OFS_TXD] <= wdata;
				regs[OFS_STAT][ST_TX_EMPTY] <= 1'b0;
				regs[OFS_STAT][ST_TX_DONE] <= 1'b0;
				tx_cnt_r <= frame_len;
			end else if (take && wr)
				regs[addr[2:0]] <= wdata;
			if (tx_cnt_r != 12'h000)
				tx_cnt_r <= tx_cnt_r - 12'h001;
			if (tx_cnt_r == 12'h001) begin
				nak_r <= 1'b0;
				// burst mode has no error exchange, so the card error flag stays clear
				if (nak_r && !burst) begin
					// card pulled the released line low in the error window
					regs[OFS_STAT][ST_CARD_ERR] <= 1'b1;
					tx_cnt_r <= 12'(FRAME_CYC);
				end else begin
					regs[OFS_STAT][ST_TX_EMPTY] <= 1'b1;
					regs[OFS_STAT][ST_TX_DONE] <= 1'b1;
					if (ctl[CT_TX_ON] && ctl[CT_RX_ON]) begin
						regs[OFS_RXD] <= regs[OFS_TXD];
						regs[OFS_STAT][ST_RX_FULL] <= 1'b1;
					end
				end
			end
			if (inj_nak)
				nak_r <= 1'b1;
			if (inj_go) begin
				regs[OFS_RXD] <= inj_byte;
				if (inj_bad)
					regs[OFS_STAT][ST_PARITY] <= 1'b1;
				else
					regs[OFS_STAT][ST_RX_FULL] <= 1'b1;
			end
			// card clock stands low until the output enable is set
			div_r <= div_r + 2'h1;
			if (!ctl[CT_CLK_OUT])
				card_clk <= 1'b0;
			else if (div_r == 2'h3)
				card_clk <= !card_clk;
		end
	end
endmodule // card_dev_model
`default_nettype wire

// file: card_host_ctrl.sv
// smart card host controller: sequences the device's registers for setup, turn-around and transfers
// Notes on behaviour
// - tx-only to duplex: wait idle, off, both
// - rx-only to duplex: rx off, flags clear, both
// - frame is start, eight data, parity
// - direct convention: no invert, LSB first, even
// - inverse convention: invert, MSB first
// - burst mode: clear parity flag each frame
// - init order: off, clear, mode, card, divisor
// - wait one bit time before enables
// - rx to tx after reception ends, reinit
// - tx to rx after tx done, reinit
`timescale 1ns/1ns
`default_nettype none
module card_host_ctrl (
	input wire logic SYS_CLK,
	input wire logic RESET,
	input wire logic CMD_VALID,
	input wire card_host_pkg::op_t CMD_OP,
	input wire logic [7:0] CMD_DATA,
	input wire card_host_pkg::cfg_t CMD_CFG,
	output logic CMD_READY,
	output logic RSP_VALID,
	output card_host_pkg::rsp_t RSP,
	output logic BUSY,
	output logic [3:0] REG_ADDR,
	output logic [7:0] REG_WDATA,
	output logic REG_WR,
	output logic REG_RD,
	input wire logic [7:0] REG_RDATA,
	input wire logic REG_ACK,
	input wire logic CARD_CLK
);
	import card_host_pkg::*;

	state_t state_r;
	state_t state_nxt;
	op_t op_r;
	cfg_t cfg_r;
	logic [7:0] data_r;
	logic pend_r;
	logic wr_r;
	logic rd_r;
	logic [3:0] addr_r;
	logic [7:0] wdata_r;
	logic [7:0] stat_r;
	logic [7:0] rxd_r;
	logic wait_done;
	logic poll_ok;
	logic [3:0] acc_addr;
	logic [7:0] acc_data;
	logic [7:0] mode_word;
	logic [7:0] cmode_word;
	logic [7:0] ctrl_clk_word;
	logic [7:0] ctrl_run_word;
	logic [7:0] clr_err_word;
	logic [7:0] clr_par_word;

	////////////////////////////////////////////////////////////////
	// access decode
	wire logic st_idle = (state_r == S_IDLE);
	wire logic acc_state = !st_idle && (state_r != S_WAIT) && (state_r != S_DONE);
	wire logic acc_read = (state_r == S_STAT_RD) || (state_r == S_POLL) || (state_r == S_RXD);
	wire logic acc_go = acc_state & ~pend_r;
	wire logic acc_done = pend_r & REG_ACK;
	wire logic wait_start = (state_r == S_CLK) & acc_done;
	wire logic take_cmd = st_idle & CMD_VALID;

	// enables written after setup; duplex ops set both in one write
	wire logic dup_op = (op_r == OP_DUP_TX) || (op_r == OP_DUP_RX);
	wire logic en_tx = (op_r == OP_INIT_TX) || (op_r == OP_TURN_TX) ||
		(op_r == OP_SELFTEST) || dup_op;
	wire logic en_rx = (op_r == OP_INIT_RX) || (op_r == OP_TURN_RX) ||
		(op_r == OP_SELFTEST) || dup_op;

	// status bits as read back in the answering cycle
	wire logic rd_tx_empty = REG_RDATA[ST_TX_EMPTY];
	wire logic rd_tx_done = REG_RDATA[ST_TX_DONE];
	wire logic rd_rx_full = REG_RDATA[ST_RX_FULL];
	wire logic rd_parity = REG_RDATA[ST_PARITY];
	wire logic rd_overrun = REG_RDATA[ST_OVERRUN];
	wire logic rd_framing = REG_RDATA[ST_FRAMING];
	wire logic rx_ended = rd_rx_full | rd_parity | rd_overrun;

	////////////////////////////////////////////////////////////////
	// register words built from the latched configuration
	always_comb begin
		mode_word = BYTE_ZERO;
		mode_word[MODE_PRESCALE_LO] = cfg_r.prescale_sel[0];
		mode_word[MODE_PRESCALE_HI] = cfg_r.prescale_sel[1];
		mode_word[MODE_RATIO_LO] = cfg_r.ratio_sel[0];
		mode_word[MODE_RATIO_HI] = cfg_r.ratio_sel[1];
		// invert leaves parity alone, so inverse needs odd parity
		mode_word[MODE_ODD] = cfg_r.inverse;
		mode_word[MODE_PARITY_ON] = 1'b1;
		mode_word[MODE_BURST] = cfg_r.burst;
		mode_word[MODE_CLK_HOLD] = cfg_r.clk_hold;
	end

	always_comb begin
		cmode_word = BYTE_ZERO;
		cmode_word[CM_SELECT] = 1'b1;
		cmode_word[CM_INVERT] = cfg_r.inverse;
		cmode_word[CM_ORDER] = cfg_r.inverse;
	end

	// clock bits only: enables, irq enables and address wait all 0
	always_comb begin
		ctrl_clk_word = BYTE_ZERO;
		ctrl_clk_word[CT_CLK_OUT] = cfg_r.clk_out_on;
		ctrl_clk_word[CT_CLK_SRC] = cfg_r.clk_src_select;
	end

	always_comb begin
		ctrl_run_word = ctrl_clk_word;
		ctrl_run_word[CT_TX_ON] = en_tx;
		ctrl_run_word[CT_RX_ON] = en_rx;
		ctrl_run_word[CT_TX_IRQ] = cfg_r.irq_on & en_tx;
		ctrl_run_word[CT_RX_IRQ] = cfg_r.irq_on & en_rx;
	end

	// write-0-to-clear: ones leave the other flags untouched
	always_comb begin
		clr_err_word = BYTE_ONES;
		clr_err_word[ST_CARD_ERR] = 1'b0;
		clr_err_word[ST_PARITY] = 1'b0;
		clr_err_word[ST_OVERRUN] = 1'b0;
		clr_par_word = BYTE_ONES;
		clr_par_word[ST_PARITY] = 1'b0;
	end

	////////////////////////////////////////////////////////////////
	// address and data of the access each state makes
	always_comb begin
		acc_addr = OFS_STAT;
		acc_data = BYTE_ZERO;
		unique case (state_r)
			S_OFF: begin
				acc_addr = OFS_CTRL;
				acc_data = ctrl_clk_word;
			end
			S_STAT_CLR: acc_data = clr_err_word;
			S_MODE: begin
				acc_addr = OFS_MODE;
				acc_data = mode_word;
			end
			S_CMODE: begin
				acc_addr = OFS_CMODE;
				acc_data = cmode_word;
			end
			S_DIV: begin
				acc_addr = OFS_DIV;
				acc_data = cfg_r.divisor;
			end
			S_CLK: begin
				acc_addr = OFS_CTRL;
				acc_data = ctrl_clk_word;
			end
			S_ENABLE: begin
				acc_addr = OFS_CTRL;
				acc_data = ctrl_run_word;
			end
			S_TXD: begin
				acc_addr = OFS_TXD;
				acc_data = data_r;
			end
			S_RXD: acc_addr = OFS_RXD;
			S_PCLR: acc_data = clr_par_word;
			default: begin
				acc_addr = OFS_STAT;
				acc_data = BYTE_ZERO;
			end
		endcase
	end

	// the status condition each operation waits for
	always_comb begin
		poll_ok = 1'b1;
		unique case (op_r)
			OP_TURN_TX: poll_ok = rx_ended;
			OP_TURN_RX: poll_ok = rd_tx_done;
			OP_SEND: poll_ok = rd_tx_empty;
			OP_RECV: poll_ok = rx_ended;
			OP_DUP_TX: poll_ok = rd_tx_empty & rd_tx_done;
			OP_DUP_RX: poll_ok = ~rd_rx_full & ~rd_parity & ~rd_overrun & ~rd_framing;
			default: poll_ok = 1'b1;
		endcase
	end

	////////////////////////////////////////////////////////////////
	// sequencer
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			S_IDLE: begin
				if (CMD_VALID) begin
					unique case (CMD_OP)
						OP_INIT_TX, OP_INIT_RX, OP_SELFTEST: state_nxt = S_OFF;
						OP_TURN_TX, OP_TURN_RX: state_nxt = S_POLL;
						OP_SEND, OP_RECV, OP_DUP_TX: state_nxt = S_POLL;
						OP_DUP_RX: state_nxt = S_OFF;
						default: state_nxt = S_DONE;
					endcase
				end
			end
			S_OFF: begin
				if (acc_done) begin
					if (op_r == OP_DUP_TX)
						state_nxt = S_ENABLE;
					else if (op_r == OP_DUP_RX)
						state_nxt = S_POLL;
					else
						state_nxt = S_STAT_RD;
				end
			end
			S_STAT_RD: if (acc_done) state_nxt = S_STAT_CLR;
			S_STAT_CLR: if (acc_done) state_nxt = S_MODE;
			S_MODE: if (acc_done) state_nxt = S_CMODE;
			S_CMODE: if (acc_done) state_nxt = S_DIV;
			S_DIV: if (acc_done) state_nxt = S_CLK;
			S_CLK: if (acc_done) state_nxt = S_WAIT;
			S_WAIT: if (wait_done) state_nxt = S_ENABLE;
			S_ENABLE: if (acc_done) state_nxt = S_DONE;
			S_POLL: begin
				if (acc_done && poll_ok) begin
					unique case (op_r)
						OP_TURN_TX, OP_TURN_RX, OP_DUP_TX: state_nxt = S_OFF;
						OP_SEND: state_nxt = S_TXD;
						OP_RECV: state_nxt = S_RXD;
						OP_DUP_RX: state_nxt = S_ENABLE;
						default: state_nxt = S_DONE;
					endcase
				end
			end
			S_TXD: if (acc_done) state_nxt = S_DONE;
			S_RXD: begin
				// parity flag must be gone before the next parity bit
				if (acc_done)
					state_nxt = stat_r[ST_PARITY] ? S_PCLR : S_DONE;
			end
			S_PCLR: if (acc_done) state_nxt = S_DONE;
			S_DONE: state_nxt = S_IDLE;
			default: state_nxt = S_IDLE;
		endcase
	end

	always_ff @(posedge SYS_CLK) begin
		if (RESET)
			state_r <= S_IDLE;
		else
			state_r <= state_nxt;
	end

	always_ff @(posedge SYS_CLK) begin
		if (RESET) begin
			op_r <= OP_INIT_TX;
			cfg_r <= '0;
			data_r <= BYTE_ZERO;
		end else if (take_cmd) begin
			op_r <= CMD_OP;
			cfg_r <= CMD_CFG;
			data_r <= CMD_DATA;
		end
	end

	////////////////////////////////////////////////////////////////
	// register port: strobe held until the device acknowledges
	always_ff @(posedge SYS_CLK) begin
		if (RESET) begin
			pend_r <= 1'b0;
			wr_r <= 1'b0;
			rd_r <= 1'b0;
		end else if (acc_go) begin
			pend_r <= 1'b1;
			wr_r <= ~acc_read;
			rd_r <= acc_read;
		end else if (acc_done) begin
			pend_r <= 1'b0;
			wr_r <= 1'b0;
			rd_r <= 1'b0;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (RESET) begin
			addr_r <= OFS_MODE;
			wdata_r <= BYTE_ZERO;
		end else if (acc_go) begin
			addr_r <= acc_addr;
			wdata_r <= acc_data;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (RESET) begin
			stat_r <= BYTE_ZERO;
			rxd_r <= BYTE_ZERO;
		end else if (acc_done && acc_read) begin
			if (state_r == S_RXD)
				rxd_r <= REG_RDATA;
			else
				stat_r <= REG_RDATA;
		end
	end

	////////////////////////////////////////////////////////////////
	// one bit time at the chosen ratio, plus a pulse of margin
	etu_waiter #(
		.CNT_W(9)
	) u_wait (
		.clk(SYS_CLK),
		.rst(RESET),
		.start(wait_start),
		.use_link(cfg_r.clk_out_on),
		.link_clk(CARD_CLK),
		.ticks(ratio_ticks(cfg_r.ratio_sel) + WAIT_MARGIN),
		.done(wait_done)
	);

	assign CMD_READY = st_idle;
	assign BUSY = ~st_idle;
	assign RSP_VALID = (state_r == S_DONE);
	assign RSP.data = rxd_r;
	assign RSP.status = stat_r;
	assign REG_ADDR = addr_r;
	assign REG_WDATA = wdata_r;
	assign REG_WR = wr_r;
	assign REG_RD = rd_r;

endmodule // card_host_ctrl
`default_nettype wire

// file: card_host_ctrl_asserts.sv
// port checks for the smart card host controller
`timescale 1ns/1ns
`default_nettype none
module card_host_ctrl_asserts (
	input wire logic SYS_CLK,
	input wire logic RESET,
	input wire logic CMD_VALID,
	input wire card_host_pkg::op_t CMD_OP,
	input wire card_host_pkg::cfg_t CMD_CFG,
	input wire logic CMD_READY,
	input wire logic RSP_VALID,
	input wire logic BUSY,
	input wire logic [3:0] REG_ADDR,
	input wire logic [7:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic REG_ACK
);
	import card_host_pkg::*;
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (RESET);
	op_t op_r;
	cfg_t cfg_r;
	wire take = CMD_VALID && CMD_READY;
	wire init_op = CMD_OP == OP_INIT_TX || CMD_OP == OP_INIT_RX || CMD_OP == OP_SELFTEST;
	wire wr_ctl = REG_WR && REG_ADDR == OFS_CTRL;
	wire both_on = REG_WDATA[CT_TX_ON] && REG_WDATA[CT_RX_ON];
	wire run_on = REG_WDATA[CT_TX_ON] || REG_WDATA[CT_RX_ON];
	wire dup_op = op_r == OP_DUP_TX || op_r == OP_DUP_RX;
	logic [11:0] gap_r;
	////////////////////////////////////////////////////////////////
	// last command and its settings, for judging the writes it causes
	always_ff @(posedge SYS_CLK) begin
		if (RESET) begin
			op_r <= OP_INIT_TX;
			cfg_r <= 16'h0000;
		end else if (take) begin
			op_r <= CMD_OP;
			cfg_r <= CMD_CFG;
		end
	end
	// cycles since the last control write with both enables off
	always_ff @(posedge SYS_CLK) begin
		if (RESET)
			gap_r <= 12'h000;
		else if (wr_ctl && !run_on)
			gap_r <= 12'h000;
		else if (gap_r != 12'hfff)
			gap_r <= gap_r + 12'h001;
	end
	////////////////////////////////////////////////////////////////
	wr_hold_a: assert property (REG_WR && !REG_ACK |=> REG_WR && $stable(REG_ADDR) && $stable(REG_WDATA))
		else $error("write moved before ack");
	rd_hold_a: assert property (REG_RD && !REG_ACK |=> REG_RD && $stable(REG_ADDR))
		else $error("read moved before ack");
	strobe_drop_a: assert property ((REG_WR || REG_RD) && REG_ACK |=> !REG_WR && !REG_RD)
		else $error("strobe held past ack");
	first_off_a: assert property (take && init_op |-> ##[1:4] wr_ctl && !REG_WDATA[CT_TX_ON] && !REG_WDATA[CT_RX_ON])
		else $error("init did not start by disabling");
	clr_word_a: assert property (REG_WR && REG_ADDR == OFS_STAT |-> !REG_WDATA[ST_PARITY] && (op_r == OP_RECV || REG_WDATA[ST_OVERRUN:ST_CARD_ERR] == 2'h0))
		else $error("flag clear word wrong");
	mode_word_a: assert property (REG_WR && REG_ADDR == OFS_MODE |-> REG_WDATA[MODE_PARITY_ON] && REG_WDATA[MODE_ODD] == cfg_r.inverse && REG_WDATA[MODE_RATIO_HI:MODE_RATIO_LO] == cfg_r.ratio_sel)
		else $error("mode word wrong");
	conv_word_a: assert property (REG_WR && REG_ADDR == OFS_CMODE |-> REG_WDATA[CM_SELECT] && REG_WDATA[CM_INVERT] == cfg_r.inverse && REG_WDATA[CM_ORDER] == cfg_r.inverse)
		else $error("card mode word wrong");
	both_on_a: assert property (wr_ctl && both_on |-> op_r == OP_SELFTEST || op_r == OP_DUP_TX || op_r == OP_DUP_RX)
		else $error("both enables outside self-test");
	turn_dir_a: assert property (wr_ctl && (op_r == OP_TURN_RX || op_r == OP_TURN_TX) |-> !REG_WDATA[op_r == OP_TURN_RX ? CT_TX_ON : CT_RX_ON])
		else $error("turn-around enabled wrong side");
	rsp_pulse_a: assert property (RSP_VALID |=> !RSP_VALID && CMD_READY && !BUSY)
		else $error("response not a single pulse");
	bit_wait_a: assert property (wr_ctl && run_on && !dup_op |->
		int'(gap_r) >= int'(ratio_ticks(cfg_r.ratio_sel)) * SYS_PER_LINK)
		else $error("enables written before one bit time");
	cover property (RSP_VALID && op_r == OP_SELFTEST);
	cover property (RSP_VALID && op_r == OP_RECV);
	cover property (RSP_VALID && op_r == OP_DUP_TX);
	cover property (RSP_VALID && op_r == OP_TURN_RX);
	cover property (RSP_VALID && op_r == OP_INIT_RX);
endmodule // card_host_ctrl_asserts
bind card_host_ctrl card_host_ctrl_asserts u_chk (.SYS_CLK, .RESET, .CMD_VALID, .CMD_OP, .CMD_CFG,
	.CMD_READY, .RSP_VALID, .BUSY, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD, .REG_ACK);
`default_nettype wire

// file: card_host_ctrl_tb_top.sv
// self-checking bench for the smart card host controller
`timescale 1ns/1ns
`default_nettype none
module card_host_ctrl_tb_top;
	import card_host_pkg::*;
	logic SYS_CLK, RESET, CMD_VALID, CMD_READY, RSP_VALID, BUSY, REG_WR, REG_RD, REG_ACK, CARD_CLK;
	op_t CMD_OP;
	cfg_t CMD_CFG;
	rsp_t RSP;
	logic [7:0] CMD_DATA, REG_WDATA, REG_RDATA, inj_byte;
	logic [3:0] REG_ADDR;
	logic inj_go, inj_bad, inj_nak;
	int n_errors = 0;
	int check_count = 0;
	card_host_ctrl u_dut (.SYS_CLK, .RESET, .CMD_VALID, .CMD_OP, .CMD_DATA, .CMD_CFG, .CMD_READY,
		.RSP_VALID, .RSP, .BUSY, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA, .REG_ACK,
		.CARD_CLK);
	card_dev_model u_dev (.clk(SYS_CLK), .rst(RESET), .addr(REG_ADDR), .wdata(REG_WDATA),
		.wr(REG_WR), .rd(REG_RD), .rdata(REG_RDATA), .ack(REG_ACK), .card_clk(CARD_CLK),
		.inj_go, .inj_bad, .inj_byte, .inj_nak);
	initial begin
		SYS_CLK = 1'b0;
		forever #20 SYS_CLK = !SYS_CLK;
	end
	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %0t %s: got %h want %h", $time, what, got, exp);
		end
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	function automatic cfg_t mk(input logic inv, input logic [1:0] r, input logic [1:0] h);
		cfg_t c;
		c = 16'h0017;
		c.inverse = inv;
		c.ratio_sel = r;
		c.prescale_sel = 2'h1;
		c.clk_out_on = 1'b1;
		c.burst = h[0];
		c.clk_hold = h[1];
		return c;
	endfunction
	// polls end on status, so the bound only guards against a hang
	task automatic cmd(input op_t op, input cfg_t c, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge SYS_CLK);
		CMD_VALID <= 1'b1;
		CMD_OP <= op;
		CMD_CFG <= c;
		CMD_DATA <= d;
		@(posedge SYS_CLK);
		CMD_VALID <= 1'b0;
		@(negedge SYS_CLK);
		while (RSP_VALID !== 1'b1 && n < 20000) begin
			@(negedge SYS_CLK);
			n++;
		end
		chk({7'h00, RSP_VALID}, 8'h01, "response");
	endtask
	task automatic regs_are(input logic [7:0] mode, input logic [7:0] cm, input logic [7:0] ctl);
		chk(u_dev.regs[OFS_MODE], mode, "mode");
		chk(u_dev.regs[OFS_CMODE], cm, "card mode");
		chk(u_dev.regs[OFS_CTRL], ctl, "control");
		chk(u_dev.regs[OFS_DIV], 8'h17, "divisor");
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_ratios();
		for (int i = 0; i < 4; i++) begin
			cmd(OP_INIT_TX, mk(1'b0, i[1:0], i[1:0]), 8'h00);
			regs_are({i[1:0], 2'b10, i[1:0], 2'h1}, 8'h01, 8'h21);
		end
		$display("test ratios done");
	endtask
	task automatic t_duplex();
		cmd(OP_DUP_RX, mk(1'b0, 2'h0, 2'h0), 8'h00);
		chk(u_dev.regs[OFS_CTRL], 8'h31, "rx to duplex");
		cmd(OP_INIT_TX, mk(1'b0, 2'h0, 2'h0), 8'h00);
		// card answers the next frame with an error signal once
		@(posedge SYS_CLK);
		inj_nak <= 1'b1;
		@(posedge SYS_CLK);
		inj_nak <= 1'b0;
		cmd(OP_SEND, mk(1'b0, 2'h0, 2'h0), 8'h3b);
		chk(u_dev.regs[OFS_TXD], 8'h3b, "tx data");
		cmd(OP_DUP_TX, mk(1'b0, 2'h0, 2'h0), 8'h00);
		chk(u_dev.regs[OFS_CTRL], 8'h31, "tx to duplex");
		chk({7'h00, u_dev.regs[OFS_STAT][ST_CARD_ERR]}, 8'h01, "card error seen");
		$display("test duplex done");
	endtask
	task automatic t_selftest();
		cmd(OP_SELFTEST, mk(1'b0, 2'h0, 2'h0), 8'h00);
		chk(u_dev.regs[OFS_CTRL], 8'h31, "self-test enables");
		chk({7'h00, u_dev.regs[OFS_STAT][ST_CARD_ERR]}, 8'h00, "card error cleared");
		cmd(OP_SEND, mk(1'b0, 2'h0, 2'h0), 8'ha5);
		cmd(OP_RECV, mk(1'b0, 2'h0, 2'h0), 8'h00);
		chk(RSP.data, 8'ha5, "looped byte");
		$display("test selftest done");
	endtask
	task automatic t_turns();
		cmd(OP_TURN_RX, mk(1'b1, 2'h0, 2'h0), 8'h00);
		regs_are(8'h31, 8'h0d, 8'h11);
		@(posedge SYS_CLK);
		inj_byte <= 8'hc3;
		inj_bad <= 1'b1;
		inj_go <= 1'b1;
		@(posedge SYS_CLK);
		inj_go <= 1'b0;
		cmd(OP_RECV, mk(1'b1, 2'h0, 2'h0), 8'h00);
		chk(RSP.data, 8'hc3, "errored byte");
		chk({7'h00, RSP.status[ST_PARITY]}, 8'h01, "parity seen");
		chk({7'h00, u_dev.regs[OFS_STAT][ST_PARITY]}, 8'h00, "parity cleared");
		cmd(OP_TURN_TX, mk(1'b0, 2'h1, 2'h0), 8'h00);
		regs_are(8'h25, 8'h01, 8'h21);
		$display("test turns done");
	endtask
	// receive init on the nominal clock with irq and clock source bits, then an unknown op
	task automatic t_rx_init();
		cfg_t c;
		c = mk(1'b0, 2'h0, 2'h0);
		c.clk_out_on = 1'b0;
		c.clk_src_select = 1'b1;
		c.irq_on = 1'b1;
		cmd(OP_INIT_RX, c, 8'h00);
		regs_are(8'h21, 8'h01, 8'h52);
		chk({7'h00, CARD_CLK}, 8'h00, "card clock off");
		cmd(op_t'(4'hf), c, 8'h00);
		chk(u_dev.regs[OFS_CTRL], 8'h52, "unknown op left control");
		$display("test rx init done");
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		RESET = 1'b1;
		CMD_VALID = 1'b0;
		CMD_OP = OP_INIT_TX;
		CMD_CFG = 16'h0000;
		CMD_DATA = 8'h00;
		inj_go = 1'b0;
		inj_bad = 1'b0;
		inj_nak = 1'b0;
		inj_byte = 8'h00;
		repeat (4) @(posedge SYS_CLK);
		RESET <= 1'b0;
		@(negedge SYS_CLK);
		chk({6'h00, CMD_READY, REG_WR | REG_RD}, 8'h02, "idle after reset");
		t_ratios();
		t_duplex();
		t_selftest();
		t_turns();
		t_rx_init();
		test_done();
	end
	// about 50000 clocks, several times the expected run
	initial begin
		#2000000;
		n_errors++;
		$display("[ERR] %0t watchdog expired", $time);
		test_done();
	end
endmodule // card_host_ctrl_tb_top
`default_nettype wire

// file: card_host_pkg.sv
// shared map, field layout, commands, states and timing for the smart card host controller
`default_nettype none
package card_host_pkg;

	// device register offsets on its register port
	localparam logic [3:0] OFS_MODE = 4'h0;
	localparam logic [3:0] OFS_DIV = 4'h1;
	localparam logic [3:0] OFS_CTRL = 4'h2;
	localparam logic [3:0] OFS_TXD = 4'h3;
	localparam logic [3:0] OFS_STAT = 4'h4;
	localparam logic [3:0] OFS_RXD = 4'h5;
	localparam logic [3:0] OFS_CMODE = 4'h6;

	// serial_mode_reg fields
	localparam int MODE_PRESCALE_LO = 0;
	localparam int MODE_PRESCALE_HI = 1;
	localparam int MODE_RATIO_LO = 2;
	localparam int MODE_RATIO_HI = 3;
	localparam int MODE_ODD = 4;
	localparam int MODE_PARITY_ON = 5;
	localparam int MODE_BURST = 6;
	localparam int MODE_CLK_HOLD = 7;

	// card_mode_reg fields
	localparam int CM_SELECT = 0;
	localparam int CM_INVERT = 2;
	localparam int CM_ORDER = 3;

	// serial_control_reg fields
	localparam int CT_CLK_OUT = 0;
	localparam int CT_CLK_SRC = 1;
	localparam int CT_DONE_IRQ = 2;
	localparam int CT_ADDR_WAIT = 3;
	localparam int CT_RX_ON = 4;
	localparam int CT_TX_ON = 5;
	localparam int CT_RX_IRQ = 6;
	localparam int CT_TX_IRQ = 7;

	// serial_status_reg fields; flags clear by writing 0
	localparam int ST_TX_DONE = 2;
	localparam int ST_PARITY = 3;
	localparam int ST_CARD_ERR = 4;
	localparam int ST_FRAMING = ST_CARD_ERR;
	localparam int ST_OVERRUN = 5;
	localparam int ST_RX_FULL = 6;
	localparam int ST_TX_EMPTY = 7;

	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [7:0] BYTE_ONES = 8'hff;

	// basic clock pulses per bit for each ratio select code
	localparam logic [8:0] RATIO_32 = 9'h020;
	localparam logic [8:0] RATIO_64 = 9'h040;
	localparam logic [8:0] RATIO_372 = 9'h174;
	localparam logic [8:0] RATIO_256 = 9'h100;
	localparam logic [8:0] WAIT_MARGIN = 9'h001;

	// nominal card clock used when the device drives no clock
	localparam int SYS_PERIOD_NS = 40;
	localparam int LINK_PERIOD_NS = 320;
	localparam int SYS_PER_LINK = (LINK_PERIOD_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;

	typedef enum logic [3:0] {
		OP_INIT_TX = 4'h0,
		OP_INIT_RX = 4'h1,
		OP_SELFTEST = 4'h2,
		OP_TURN_TX = 4'h3,
		OP_TURN_RX = 4'h4,
		OP_SEND = 4'h5,
		OP_RECV = 4'h6,
		OP_DUP_TX = 4'h7,
		OP_DUP_RX = 4'h8
	} op_t;

	typedef enum logic [3:0] {
		S_IDLE = 4'h0,
		S_OFF = 4'h1,
		S_STAT_RD = 4'h2,
		S_STAT_CLR = 4'h3,
		S_MODE = 4'h4,
		S_CMODE = 4'h5,
		S_DIV = 4'h6,
		S_CLK = 4'h7,
		S_WAIT = 4'h8,
		S_ENABLE = 4'h9,
		S_POLL = 4'ha,
		S_TXD = 4'hb,
		S_RXD = 4'hc,
		S_PCLR = 4'hd,
		S_DONE = 4'he
	} state_t;

	typedef struct packed {
		logic inverse;
		logic burst;
		logic clk_hold;
		logic clk_out_on;
		logic clk_src_select;
		logic irq_on;
		logic [1:0] ratio_sel;
		logic [1:0] prescale_sel;
		logic [7:0] divisor;
	} cfg_t;

	typedef struct packed {
		logic [7:0] data;
		logic [7:0] status;
	} rsp_t;

	function automatic logic [8:0] ratio_ticks(input logic [1:0] sel);
		logic [8:0] r;
		r = RATIO_32;
		case (sel)
			2'h0: r = RATIO_32;
			2'h1: r = RATIO_64;
			2'h2: r = RATIO_372;
			2'h3: r = RATIO_256;
			default: r = RATIO_32;
		endcase
		return r;
	endfunction

endpackage
`default_nettype wire

// file: etu_waiter.sv
// bit time waiter: counts card clock rising edges, or a nominal clock when none is driven
`timescale 1ns/1ns
`default_nettype none
module etu_waiter #(
	parameter int CNT_W = 9
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic start,
	input wire logic use_link,
	input wire logic link_clk,
	input wire logic [CNT_W-1:0] ticks,
	output logic done
);
	import card_host_pkg::*;

	logic sync1_r;
	logic sync2_r;
	logic sync3_r;
	logic [3:0] div_r;
	logic [CNT_W-1:0] cnt_r;
	logic run_r;
	logic done_r;

	wire logic link_rise = sync2_r & ~sync3_r;
	wire logic div_last = (div_r == 4'(SYS_PER_LINK - 1));
	wire logic tick = use_link ? link_rise : div_last;
	wire logic last = run_r & tick & (cnt_r == CNT_W'(1));

	////////////////////////////////////////////////////////////////
	always_ff @(posedge clk) begin
		if (rst) begin
			sync1_r <= 1'b0;
			sync2_r <= 1'b0;
			sync3_r <= 1'b0;
		end else begin
			sync1_r <= link_clk;
			sync2_r <= sync1_r;
			sync3_r <= sync2_r;
		end
	end

	always_ff @(posedge clk) begin
		if (rst || start || div_last)
			div_r <= 4'h0;
		else
			div_r <= div_r + 4'h1;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_r <= '0;
			run_r <= 1'b0;
			done_r <= 1'b0;
		end else if (start) begin
			cnt_r <= ticks;
			run_r <= 1'b1;
			done_r <= 1'b0;
		end else if (last) begin
			run_r <= 1'b0;
			done_r <= 1'b1;
		end else if (run_r && tick) begin
			cnt_r <= cnt_r - CNT_W'(1);
		end
	end

	assign done = done_r;

endmodule // etu_waiter
`default_nettype wire
